// >>> rtl/tcc_defs.vh
// Register indices, field positions, reset values and mode codes of the timer and capture/compare block.
// Assumes a 32-bit APB master; byte address of a register is four times its index.
`ifndef TCC_DEFS_VH
`define TCC_DEFS_VH
`define TCC_IDX_W 8
`define TCC_IDX_PERIPHERAL_FLAGS 8'h0C
`define TCC_IDX_TIMER1_COUNT_LOW 8'h0E
`define TCC_IDX_TIMER1_COUNT_HIGH 8'h0F
`define TCC_IDX_TIMER1_CONTROL 8'h10
`define TCC_IDX_TIMER2_COUNT 8'h11
`define TCC_IDX_TIMER2_CONTROL 8'h12
`define TCC_IDX_CC_LOW_BYTE 8'h15
`define TCC_IDX_CC_HIGH_BYTE 8'h16
`define TCC_IDX_CCP_CONTROL 8'h17
`define TCC_IDX_PERIPHERAL_ENABLES 8'h8C
`define TCC_IDX_TIMER2_PERIOD 8'h92
`define TCC_RST_FLAGS 8'h00
`define TCC_RST_ENABLES 8'h00
`define TCC_RST_T1CTRL 8'h00
`define TCC_RST_T2COUNT 8'h00
`define TCC_RST_T2CTRL 8'h00
`define TCC_RST_T2PERIOD 8'hFF
`define TCC_RST_CCPCTRL 8'h00
`define TCC_FLAG_T1_OVF 0
`define TCC_FLAG_T2_MATCH 1
`define TCC_FLAG_CCP_EVENT 2
`define TCC_FLAG_MASK 8'h07
`define TCC_ENABLE_MASK 8'h47
`define TCC_T1CTRL_MASK 8'h3F
`define TCC_T1_RUN 0
`define TCC_T1_PRE_LSB 4
`define TCC_T2CTRL_MASK 8'h7F
`define TCC_T2_RUN 2
`define TCC_T2_PRE_LSB 0
`define TCC_T2_POST_LSB 3
`define TCC_CCPCTRL_MASK 8'h3F
`define TCC_CCP_DUTY_LSB 4
`define TCC_MODE_OFF 4'h0
`define TCC_MODE_CAP_FALL 4'h4
`define TCC_MODE_CAP_RISE 4'h5
`define TCC_MODE_CAP_RISE4 4'h6
`define TCC_MODE_CAP_RISE16 4'h7
`define TCC_MODE_CMP_SET 4'h8
`define TCC_MODE_CMP_CLEAR 4'h9
`define TCC_MODE_CMP_SOFT 4'hA
`define TCC_MODE_CMP_SPECIAL 4'hB
`endif

// >>> rtl/tcc_timer_ccp.v
// Timer2 period timer, a small Timer1 time base and the capture/compare/PWM unit behind an APB slave.
// Assumes one clock (instruction clock), an asynchronous pin input and an A/D enable level from the same clock.
`timescale 1ns/1ps
`include "tcc_defs.vh"

module tcc_timer_ccp (
  input wire i_mclk,
  input wire i_rst_b,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  input wire i_ccp_pin,
  input wire i_adc_enable,
  output reg o_ccp_pin_out,
  output reg o_ccp_pin_oe,
  output reg o_adc_start,
  output reg o_timer2_match
);

  function is_mapped;
    input [`TCC_IDX_W-1:0] idx;
    begin
      case (idx)
        `TCC_IDX_PERIPHERAL_FLAGS, `TCC_IDX_TIMER1_COUNT_LOW, `TCC_IDX_TIMER1_COUNT_HIGH,
        `TCC_IDX_TIMER1_CONTROL, `TCC_IDX_TIMER2_COUNT, `TCC_IDX_TIMER2_CONTROL,
        `TCC_IDX_CC_LOW_BYTE, `TCC_IDX_CC_HIGH_BYTE, `TCC_IDX_CCP_CONTROL,
        `TCC_IDX_PERIPHERAL_ENABLES, `TCC_IDX_TIMER2_PERIOD: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction

  reg [7:0] flags_q;
  reg [7:0] enables_q;
  reg [15:0] t1_count_q;
  reg [7:0] t1_ctrl_q;
  reg [2:0] t1_pre_q;
  reg [7:0] t2_count_q;
  reg [7:0] t2_ctrl_q;
  reg [7:0] t2_period_q;
  reg [3:0] t2_pre_q;
  reg [3:0] t2_post_q;
  reg [15:0] cc_value_q;
  reg [7:0] ccp_ctrl_q;
  reg [3:0] edge_pre_q;
  reg [9:0] duty_q;
  reg cmp_eq_q;
  reg pin_meta_q;
  reg pin_sync_q;
  reg pin_prev_q;

  wire [`TCC_IDX_W-1:0] idx = i_paddr[`TCC_IDX_W+1:2];
  wire access = i_psel & i_penable;
  wire wr = access & i_pwrite & o_pready & ~o_pslverr;
  wire wr_flags = wr & (idx == `TCC_IDX_PERIPHERAL_FLAGS);
  wire wr_t1_lo = wr & (idx == `TCC_IDX_TIMER1_COUNT_LOW);
  wire wr_t1_hi = wr & (idx == `TCC_IDX_TIMER1_COUNT_HIGH);
  wire wr_t2 = wr & (idx == `TCC_IDX_TIMER2_COUNT);
  wire wr_t2_ctrl = wr & (idx == `TCC_IDX_TIMER2_CONTROL);
  wire wr_cc_lo = wr & (idx == `TCC_IDX_CC_LOW_BYTE);
  wire wr_cc_hi = wr & (idx == `TCC_IDX_CC_HIGH_BYTE);
  wire wr_ccp_ctrl = wr & (idx == `TCC_IDX_CCP_CONTROL);

  wire [3:0] mode = ccp_ctrl_q[3:0];
  // Codes one to three fall in no class and so act like off without resetting.
  wire mode_off = (mode == `TCC_MODE_OFF);
  wire mode_capture = (mode[3:2] == 2'b01);
  wire mode_compare = (mode[3:2] == 2'b10);
  wire mode_pwm = (mode[3:2] == 2'b11);

  // Timer1 time base with a 1, 2, 4 or 8 prescaler.
  reg [2:0] t1_pre_mask;
  always @* begin
    case (t1_ctrl_q[`TCC_T1_PRE_LSB+1:`TCC_T1_PRE_LSB])
      2'b00: t1_pre_mask = 3'h0;
      2'b01: t1_pre_mask = 3'h1;
      2'b10: t1_pre_mask = 3'h3;
      default: t1_pre_mask = 3'h7;
    endcase
  end
  wire t1_run = t1_ctrl_q[`TCC_T1_RUN];
  wire t1_tick = t1_run & ((t1_pre_q & t1_pre_mask) == t1_pre_mask);
  wire t1_ovf = t1_tick & (t1_count_q == 16'hFFFF);

  // Compare looks at Timer1 on every clock; one hit per arrival at equality.
  wire cmp_eq = (t1_count_q == cc_value_q);
  wire cmp_hit = mode_compare & cmp_eq & ~cmp_eq_q;
  wire special = cmp_hit & (mode == `TCC_MODE_CMP_SPECIAL);

  // Timer2 prescaler ratio 1, 4 or 16.
  reg [3:0] t2_pre_last;
  always @* begin
    case (t2_ctrl_q[`TCC_T2_PRE_LSB+1:`TCC_T2_PRE_LSB])
      2'b00: t2_pre_last = 4'h0;
      2'b01: t2_pre_last = 4'h3;
      default: t2_pre_last = 4'hF;
    endcase
  end
  wire t2_run = t2_ctrl_q[`TCC_T2_RUN];
  wire t2_tick = t2_run & (t2_pre_q == t2_pre_last);
  wire t2_match = t2_tick & (t2_count_q == t2_period_q);
  wire [3:0] t2_post_sel = t2_ctrl_q[`TCC_T2_POST_LSB+3:`TCC_T2_POST_LSB];
  wire t2_post_fire = t2_match & (t2_post_q == t2_post_sel);

  // Capture edge detection runs on the second synchroniser stage only.
  wire pin_rise = pin_sync_q & ~pin_prev_q;
  wire pin_fall = ~pin_sync_q & pin_prev_q;
  reg cap_event;
  always @* begin
    case (mode)
      `TCC_MODE_CAP_FALL: cap_event = pin_fall;
      `TCC_MODE_CAP_RISE: cap_event = pin_rise;
      `TCC_MODE_CAP_RISE4: cap_event = pin_rise & (edge_pre_q[1:0] == 2'h3);
      `TCC_MODE_CAP_RISE16: cap_event = pin_rise & (edge_pre_q == 4'hF);
      default: cap_event = 1'b0;
    endcase
  end

  // PWM time base extends Timer2 by two prescaler bits.
  reg [1:0] pwm_ext;
  always @* begin
    case (t2_ctrl_q[`TCC_T2_PRE_LSB+1:`TCC_T2_PRE_LSB])
      2'b00: pwm_ext = 2'b00;
      2'b01: pwm_ext = t2_pre_q[1:0];
      default: pwm_ext = t2_pre_q[3:2];
    endcase
  end
  wire [9:0] pwm_new_duty = {cc_value_q[7:0], ccp_ctrl_q[`TCC_CCP_DUTY_LSB+1:`TCC_CCP_DUTY_LSB]};

  // APB slave: access lasts two cycles, pready registered.
  reg [7:0] rd_byte;
  always @* begin
    case (idx)
      `TCC_IDX_PERIPHERAL_FLAGS: rd_byte = flags_q;
      `TCC_IDX_TIMER1_COUNT_LOW: rd_byte = t1_count_q[7:0];
      `TCC_IDX_TIMER1_COUNT_HIGH: rd_byte = t1_count_q[15:8];
      `TCC_IDX_TIMER1_CONTROL: rd_byte = t1_ctrl_q;
      `TCC_IDX_TIMER2_COUNT: rd_byte = t2_count_q;
      `TCC_IDX_TIMER2_CONTROL: rd_byte = t2_ctrl_q;
      `TCC_IDX_CC_LOW_BYTE: rd_byte = cc_value_q[7:0];
      `TCC_IDX_CC_HIGH_BYTE: rd_byte = cc_value_q[15:8];
      `TCC_IDX_CCP_CONTROL: rd_byte = ccp_ctrl_q;
      `TCC_IDX_PERIPHERAL_ENABLES: rd_byte = enables_q;
      `TCC_IDX_TIMER2_PERIOD: rd_byte = t2_period_q;
      default: rd_byte = 8'h00;
    endcase
  end

  always @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h00000000;
    end else if (access & ~o_pready) begin
      o_pready <= 1'b1;
      o_pslverr <= ~is_mapped(idx) | (|i_paddr[11:`TCC_IDX_W+2]);
      o_prdata <= (is_mapped(idx) & ~i_pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
    end else begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end
  end

  // Software-visible control registers.
  always @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      enables_q <= `TCC_RST_ENABLES;
      t1_ctrl_q <= `TCC_RST_T1CTRL;
      t2_ctrl_q <= `TCC_RST_T2CTRL;
      t2_period_q <= `TCC_RST_T2PERIOD;
      ccp_ctrl_q <= `TCC_RST_CCPCTRL;
    end else begin
      if (wr & (idx == `TCC_IDX_PERIPHERAL_ENABLES))
        enables_q <= i_pwdata[7:0] & `TCC_ENABLE_MASK;
      if (wr & (idx == `TCC_IDX_TIMER1_CONTROL))
        t1_ctrl_q <= i_pwdata[7:0] & `TCC_T1CTRL_MASK;
      if (wr_t2_ctrl)
        t2_ctrl_q <= i_pwdata[7:0] & `TCC_T2CTRL_MASK;
      if (wr & (idx == `TCC_IDX_TIMER2_PERIOD))
        t2_period_q <= i_pwdata[7:0];
      if (wr_ccp_ctrl)
        ccp_ctrl_q <= i_pwdata[7:0] & `TCC_CCPCTRL_MASK;
    end
  end

  // Flags: a hardware set in the cycle of a software write wins.
  always @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flags_q <= `TCC_RST_FLAGS;
    end else begin
      flags_q <= ((wr_flags ? i_pwdata[7:0] : flags_q) & `TCC_FLAG_MASK)
        | ({7'h00, t1_ovf & ~special} << `TCC_FLAG_T1_OVF)
        | ({7'h00, t2_post_fire} << `TCC_FLAG_T2_MATCH)
        | ({7'h00, cap_event | cmp_hit} << `TCC_FLAG_CCP_EVENT);
    end
  end

  // Timer1 count; a byte write beats the special-event reset.
  always @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      t1_count_q <= 16'h0000;
      t1_pre_q <= 3'h0;
    end else begin
      t1_pre_q <= t1_run ? t1_pre_q + 3'h1 : t1_pre_q;
      if (wr_t1_lo)
        t1_count_q[7:0] <= i_pwdata[7:0];
      else if (wr_t1_hi)
        t1_count_q[15:8] <= i_pwdata[7:0];
      else if (special)
        t1_count_q <= 16'h0000;
      else if (t1_tick)
        t1_count_q <= t1_count_q + 16'h0001;
    end
  end

  // Timer2 with prescaler and postscaler.
  always @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      t2_count_q <= `TCC_RST_T2COUNT;
      t2_pre_q <= 4'h0;
      t2_post_q <= 4'h0;
      o_timer2_match <= 1'b0;
    end else begin
      o_timer2_match <= t2_match;
      if (wr_t2 | wr_t2_ctrl) begin
        t2_pre_q <= 4'h0;
        t2_post_q <= 4'h0;
      end else begin
        if (t2_run)
          t2_pre_q <= t2_tick ? 4'h0 : t2_pre_q + 4'h1;
        if (t2_match)
          t2_post_q <= t2_post_fire ? 4'h0 : t2_post_q + 4'h1;
      end
      if (wr_t2)
        t2_count_q <= i_pwdata[7:0];
      else if (t2_match)
        t2_count_q <= 8'h00;
      else if (t2_tick)
        t2_count_q <= t2_count_q + 8'h01;
    end
  end

  // Pin synchroniser and capture edge prescaler.
  always @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
      pin_prev_q <= 1'b0;
      edge_pre_q <= 4'h0;
      cmp_eq_q <= 1'b0;
    end else begin
      pin_meta_q <= i_ccp_pin;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
      cmp_eq_q <= mode_compare & cmp_eq;
      if (!mode_capture)
        edge_pre_q <= 4'h0;
      else if (pin_rise)
        edge_pre_q <= edge_pre_q + 4'h1;
    end
  end

  // Capture/compare value, pin latch, PWM duty and trigger output.
  always @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cc_value_q <= 16'h0000;
      duty_q <= 10'h000;
      o_ccp_pin_out <= 1'b0;
      o_ccp_pin_oe <= 1'b0;
      o_adc_start <= 1'b0;
    end else begin
      o_adc_start <= special & i_adc_enable;
      o_ccp_pin_oe <= mode_compare | mode_pwm;
      if (cap_event) begin
        cc_value_q <= t1_count_q;
      end else begin
        if (wr_cc_lo)
          cc_value_q[7:0] <= i_pwdata[7:0];
        if (wr_cc_hi)
          cc_value_q[15:8] <= i_pwdata[7:0];
      end
      if (mode_off) begin
        o_ccp_pin_out <= 1'b0;
      end else if (cmp_hit & (mode == `TCC_MODE_CMP_SET)) begin
        o_ccp_pin_out <= 1'b1;
      end else if (cmp_hit & (mode == `TCC_MODE_CMP_CLEAR)) begin
        o_ccp_pin_out <= 1'b0;
      end else if (mode_pwm & t2_match) begin
        duty_q <= pwm_new_duty;
        o_ccp_pin_out <= (pwm_new_duty != 10'h000);
      end else if (mode_pwm & ({t2_count_q, pwm_ext} >= duty_q)) begin
        o_ccp_pin_out <= 1'b0;
      end
    end
  end

endmodule

// >>> dv/tcc_timer_ccp_asserts.sv
// Port checker for tcc_timer_ccp, bound to every instance.
// Assumes writes land at the edge where pready is sampled high.
`timescale 1ns/1ps
module tcc_timer_ccp_asserts (
  input wire i_mclk,
  input wire i_rst_b,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [31:0] o_prdata,
  input wire o_pready,
  input wire o_pslverr,
  input wire i_adc_enable,
  input wire o_ccp_pin_out,
  input wire o_ccp_pin_oe,
  input wire o_adc_start,
  input wire o_timer2_match
);
  reg [3:0] mode_q;
  reg run_q;
  wire wr_ok = i_psel && i_penable && i_pwrite && o_pready && !o_pslverr;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  // Shadows of the mode field and the Timer2 run bit.
  always @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode_q <= 4'h0;
      run_q <= 1'b0;
    end else if (wr_ok && i_paddr[9:2] == 8'h17) begin
      mode_q <= i_pwdata[3:0];
    end else if (wr_ok && i_paddr[9:2] == 8'h12) begin
      run_q <= i_pwdata[2];
    end
  end
  sequence s_access; i_psel && i_penable && !o_pready; endsequence
  sequence s_answer; o_pready ##1 !o_pready; endsequence
  property p_apb_wait; s_access |=> s_answer; endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("APB answer late");
  property p_byte_data; o_pready |-> o_prdata[31:8] == 24'h0; endproperty
  a_byte_data: assert property (p_byte_data) else $error("Read data above byte");
  property p_adc_cause; o_adc_start |-> mode_q == 4'hB && $past(i_adc_enable); endproperty
  a_adc_cause: assert property (p_adc_cause) else $error("Stray conversion start");
  property p_adc_pulse; o_adc_start |=> !o_adc_start; endproperty
  a_adc_pulse: assert property (p_adc_pulse) else $error("Conversion start too long");
  property p_oe_mode; o_ccp_pin_oe == ($past(mode_q) >= 4'h8); endproperty
  a_oe_mode: assert property (p_oe_mode) else $error("Pin enable wrong for mode");
  property p_off_low; mode_q == 4'h0 && $past(mode_q) == 4'h0 |-> !o_ccp_pin_out; endproperty
  a_off_low: assert property (p_off_low) else $error("Pin latch high while off");
  property p_pin_hold; mode_q inside {4'h1, 4'h2, 4'h3, 4'hA} && $stable(mode_q) |-> $stable(o_ccp_pin_out);
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("Pin moved in hold mode");
  property p_match_run; o_timer2_match |-> $past(run_q); endproperty
  a_match_run: assert property (p_match_run) else $error("Timer2 match while stopped");
endmodule
bind tcc_timer_ccp tcc_timer_ccp_asserts u_chk (.i_mclk, .i_rst_b, .i_psel, .i_penable, .i_pwrite,
  .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_adc_enable, .o_ccp_pin_out,
  .o_ccp_pin_oe, .o_adc_start, .o_timer2_match);

// >>> dv/tcc_pin_model.sv
// Model of the external event source on the capture pin.
// Assumes the bench asks for one pulse train at a time.
`timescale 1ns/1ps
module tcc_pin_model (
  input wire i_mclk,
  input wire i_go,
  input wire [4:0] i_count,
  output logic o_pin,
  output logic o_busy
);
  logic [4:0] left_q;
  logic [2:0] ph_q;
  initial begin
    o_pin = 1'b0;
    o_busy = 1'b0;
  end
  // Each level stands three clocks or more so the synchroniser sees every edge.
  always @(posedge i_mclk) begin
    if (i_go) begin
      left_q <= i_count;
      ph_q <= 3'h0;
      o_busy <= i_count != 5'h0;
    end else if (o_busy) begin
      ph_q <= ph_q + 3'h1;
      o_pin <= ph_q[2] && ph_q != 3'h7;
      if (ph_q == 3'h7) begin
        left_q <= left_q - 5'h1;
        o_busy <= left_q != 5'h1;
      end
    end
  end
endmodule

// >>> dv/test_timer2_and_ccp_capture_compare.sv
// Bench for tcc_timer_ccp: registers, Timer2, capture and compare.
// Assumes the pin model drives the capture pin whenever the unit does not.
`timescale 1ns/1ps
module test_timer2_and_ccp_capture_compare;
  logic clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0, adc_en = 0, go = 0, err, busy, pin_m;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [4:0] pcnt = 0;
  logic [7:0] rv;
  logic [3:0] md;
  logic [23:0] modes = 24'hA8BB98;
  logic [5:0] pins = 6'b110001;
  wire [31:0] prdata;
  wire pready, pslverr, pin_out, pin_oe, adc_start, t2m;
  wire ccp = pin_oe ? pin_out : pin_m;
  int bad_count = 0, cmp_count = 0, m_cnt = 0, a_cnt = 0, h_cnt = 0, s, n;
  tcc_timer_ccp i_dut (.i_mclk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_ccp_pin(ccp), .i_adc_enable(adc_en), .o_ccp_pin_out(pin_out), .o_ccp_pin_oe(pin_oe),
    .o_adc_start(adc_start), .o_timer2_match(t2m));
  tcc_pin_model i_pin (.i_mclk(clk), .i_go(go), .i_count(pcnt), .o_pin(pin_m), .o_busy(busy));
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    if (t2m === 1'b1) m_cnt <= m_cnt + 1;
    if (adc_start === 1'b1) a_cnt <= a_cnt + 1;
    if (pin_out === 1'b1) h_cnt <= h_cnt + 1;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) bad_count++;
    rv = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    chk($sformatf("reg %h", idx), {8'h0, e}, {8'h0, rv});
  endtask
  task automatic pulse(input int c);
    int k;
    k = 0;
    @(posedge clk);
    go <= 1'b1;
    pcnt <= 5'(c);
    @(posedge clk);
    go <= 1'b0;
    do begin
      @(posedge clk);
      k++;
    end while (busy === 1'b1 && k < 300);
    if (k >= 300) bad_count++;
    repeat (6) @(posedge clk);
  endtask
  task automatic win(input int e);
    s = m_cnt;
    repeat (64) @(posedge clk);
    chk("matches", 16'(e), 16'(m_cnt - s));
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    tally_and_finish;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    rdc(8'h11, 8'h00);
    rdc(8'h92, 8'hFF);
    rdc(8'h17, 8'h00);
    wr(8'h92, 8'h5A);
    rdc(8'h92, 8'h5A);
    wr(8'h16, 8'h3C);
    rdc(8'h16, 8'h3C);
    wr(8'h17, 8'h33);
    rdc(8'h17, 8'h33);
    for (int m = 1; m < 4; m++) wr(8'h17, 8'(m));
    wr(8'h0B, 8'h00);
    chk("slverr", 16'h1, {15'h0, err});
    wr(8'h11, 8'h02);
    wr(8'h12, 8'h01);
    rdc(8'h11, 8'h02);
    $display("test registers done");
    wr(8'h92, 8'h03);
    for (int p = 0; p < 3; p++) begin
      wr(8'h12, 8'h0C | 8'(p));
      repeat (8) @(posedge clk);
      win(16 >> (2 * p));
    end
    rdc(8'h0C, 8'h02);
    wr(8'h12, 8'h08);
    wr(8'h0C, 8'h00);
    wr(8'h12, 8'h7C);
    repeat (36) @(posedge clk);
    rdc(8'h0C, 8'h00);
    repeat (40) @(posedge clk);
    rdc(8'h0C, 8'h02);
    wr(8'h12, 8'h78);
    repeat (2) @(posedge clk);
    win(0);
    $display("test timer2 done");
    wr(8'h10, 8'h00);
    for (int i = 0; i < 4; i++) begin
      n = (i < 2) ? 1 : 4 << (2 * (i - 2));
      wr(8'h17, 8'h00);
      wr(8'h0C, 8'h00);
      wr(8'h0E, 8'h11 * 8'(i));
      wr(8'h0F, 8'hA0 | 8'(i));
      wr(8'h17, 8'h04 | 8'(i));
      pulse(n - 1);
      rdc(8'h0C, 8'h00);
      pulse(1);
      rdc(8'h0C, 8'h04);
      rdc(8'h15, 8'h11 * 8'(i));
      rdc(8'h16, 8'hA0 | 8'(i));
    end
    wr(8'h17, 8'h05);
    pulse(1);
    wr(8'h0E, 8'h6B);
    pulse(1);
    rdc(8'h15, 8'h6B);
    $display("test capture done");
    wr(8'h15, 8'h10);
    wr(8'h16, 8'h00);
    for (int k = 0; k < 6; k++) begin
      md = modes[4 * k +: 4];
      adc_en <= (k != 3);
      wr(8'h10, 8'h00);
      wr(8'h0E, 8'h00);
      wr(8'h0F, 8'h00);
      wr(8'h0C, 8'h00);
      wr(8'h17, {4'h0, md});
      s = a_cnt;
      wr(8'h10, 8'h01);
      repeat (40) @(posedge clk);
      wr(8'h10, 8'h00);
      rdc(8'h0C, 8'h04);
      chk("pin", {15'h0, pins[k]}, {15'h0, pin_out});
      chk("adc", {15'h0, k == 2}, {15'h0, a_cnt != s});
      apb(1'b0, 8'h0E, 8'h00);
      chk("t1 reset", 16'h1, {15'h0, (rv <= 8'h10) == (md == 4'hB)});
    end
    $display("test compare done");
    wr(8'h12, 8'h04);
    wr(8'h15, 8'h02);
    wr(8'h17, 8'h0C);
    repeat (8) @(posedge clk);
    n = h_cnt;
    win(16);
    chk("pwm high", 16'h1, {15'h0, h_cnt != n && h_cnt - n < 64});
    chk("pwm oe", 16'h1, {15'h0, pin_oe});
    wr(8'h15, 8'h00);
    repeat (8) @(posedge clk);
    n = h_cnt;
    repeat (64) @(posedge clk);
    chk("pwm zero", 16'h0, 16'(h_cnt - n));
    wr(8'h12, 8'h00);
    wr(8'h17, 8'h00);
    repeat (3) @(posedge clk);
    chk("pin off", 16'h0, {14'h0, pin_oe, pin_out});
    $display("test pwm done");
    tally_and_finish;
  end
endmodule
